// ===== rtl/fes_mem.sv
// write port sweeper that drives fill writes into the flash array
module fes_mem #(
	parameter int ADDR_W = 13
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// sweep request
	input wire logic start,
	input wire logic [ADDR_W-1:0] base,
	input wire logic [ADDR_W:0] len,
	// array write port
	output logic wr_en,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [7:0] wr_data,
	output logic done
);
	typedef struct packed {
		logic busy;
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W:0] left;
		logic wr_en;
		logic done;
	} fes_mem_s;
	fes_mem_s st_reg;
	fes_mem_s st_next;
	//==============================
	// one erased byte per cycle
	always_comb
	begin
		st_next = st_reg;
		st_next.wr_en = 1'b0;
		st_next.done = 1'b0;
		if (start)
		begin
			st_next.busy = 1'b1;
			st_next.addr = base;
			st_next.left = len;
		end
		else if (st_reg.busy)
		begin
			st_next.wr_en = 1'b1;
			if (st_reg.left == (ADDR_W+1)'(1))
			begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
			end
			st_next.left = st_reg.left - (ADDR_W+1)'(1);
		end
		if (st_reg.wr_en)
			st_next.addr = st_reg.addr + ADDR_W'(1);
	end
	//==============================
	// state register
	always_ff @(posedge clk)
	begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign wr_en = st_reg.wr_en;
	assign wr_addr = st_reg.addr;
	assign wr_data = fes_pkg::ERASED_BYTE;
	assign done = st_reg.done;
endmodule

// ===== rtl/fes_timer.sv
// countdown timer for erase pulse width
module fes_timer #(
	parameter int CNT_W = 20
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic load,
	input wire logic [CNT_W-1:0] count,
	// status
	output logic done
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic run;
		logic done;
	} fes_tmr_s;
	fes_tmr_s st_reg;
	fes_tmr_s st_next;
	//==============================
	// next state
	always_comb
	begin
		st_next = st_reg;
		st_next.done = 1'b0;
		if (load)
		begin
			st_next.cnt = count;
			st_next.run = 1'b1;
		end
		else if (st_reg.run)
		begin
			if (st_reg.cnt <= CNT_W'(1))
			begin
				st_next.run = 1'b0;
				st_next.done = 1'b1;
			end
			st_next.cnt = st_reg.cnt - CNT_W'(1);
		end
	end
	//==============================
	// state register
	always_ff @(posedge clk)
	begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign done = st_reg.done;
endmodule

// ===== rtl/fes_top.sv
// flash erase sequencer: command decode, lock, stall, status, bypass
module fes_top #(
	parameter int ADDR_W = 13,
	parameter int PAGE_W = 4,
	parameter int SECT_N = 8,
	parameter int PAGE_ERASE_CYC = fes_pkg::PAGE_ERASE_CYC,
	parameter int MASS_ERASE_CYC = fes_pkg::MASS_ERASE_CYC,
	parameter int TMR_W = 20
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control register write
	input wire logic ctl_wr,
	input wire logic [7:0] ctl_wdata,
	input wire logic ctl_from_dbg,
	// page select and protection
	input wire logic [PAGE_W-1:0] page_sel,
	input wire logic [SECT_N-1:0] sect_protect,
	// bypass pins
	input wire logic bypass_en,
	input wire logic pin_wr_en,
	input wire logic [ADDR_W-1:0] pin_addr,
	input wire logic [7:0] pin_data,
	input wire logic pin_page_erase,
	input wire logic pin_mass_erase,
	// status
	output logic busy,
	output logic unlocked,
	output logic cpu_stall,
	output logic cmd_rejected,
	// flash array port
	output logic fl_wr_en,
	output logic [ADDR_W-1:0] fl_addr,
	output logic [7:0] fl_data
);
	localparam int SECT_W = $clog2(SECT_N);
	typedef struct packed {
		fes_pkg::fes_state_e state;
		logic [PAGE_W-1:0] page;
		logic is_mass;
		logic busy;
		logic stall;
		logic rej;
		logic unl;
		logic fl_wr_en;
		logic [ADDR_W-1:0] fl_addr;
		logic [7:0] fl_data;
	} fes_top_s;
	fes_top_s st_reg;
	fes_top_s st_next;
	logic tmr_load;
	logic [TMR_W-1:0] tmr_count;
	logic tmr_done;
	logic sw_start;
	logic [ADDR_W-1:0] sw_base;
	logic [ADDR_W:0] sw_len;
	logic sw_wr;
	logic [ADDR_W-1:0] sw_addr;
	logic [7:0] sw_data;
	logic sw_done;
	//==============================
	// page to sector protection lookup
	function automatic logic page_protected(input logic [PAGE_W-1:0] pg,
		input logic [SECT_N-1:0] prot);
		logic [SECT_W-1:0] s;
		s = SECT_W'(pg >> (PAGE_W - SECT_W));
		return prot[s];
	endfunction
	//==============================
	// page base address
	function automatic logic [ADDR_W-1:0] page_base(input logic [PAGE_W-1:0] pg);
		return ADDR_W'({pg, {fes_pkg::PAGE_ADDR_W{1'b0}}});
	endfunction
	//==============================
	// helpers
	fes_timer #(.CNT_W(TMR_W)) u_timer (
		.clk(clk),
		.rst(rst),
		.load(tmr_load),
		.count(tmr_count),
		.done(tmr_done)
	);
	fes_mem #(.ADDR_W(ADDR_W)) u_sweep (
		.clk(clk),
		.rst(rst),
		.start(sw_start),
		.base(sw_base),
		.len(sw_len),
		.wr_en(sw_wr),
		.wr_addr(sw_addr),
		.wr_data(sw_data),
		.done(sw_done)
	);
	//==============================
	// command sequencing
	always_comb
	begin
		logic pg_req;
		logic ms_req;
		pg_req = 1'b0;
		ms_req = 1'b0;
		st_next = st_reg;
		st_next.rej = 1'b0;
		tmr_load = 1'b0;
		tmr_count = '0;
		sw_start = 1'b0;
		sw_base = page_base(st_reg.page);
		sw_len = (ADDR_W+1)'(fes_pkg::PAGE_BYTES);
		if (bypass_en)
		begin
			pg_req = pin_page_erase;
			ms_req = pin_mass_erase;
		end
		else if (ctl_wr)
		begin
			pg_req = (ctl_wdata == fes_pkg::CMD_PAGE_ERASE);
			ms_req = (ctl_wdata == fes_pkg::CMD_MASS_ERASE);
		end
		case (st_reg.state)
			fes_pkg::FES_LOCKED:
			begin
				if (!bypass_en && ctl_wr)
				begin
					if (ctl_wdata == fes_pkg::KEY_FIRST)
						st_next.state = fes_pkg::FES_KEY1;
					else
						st_next.rej = 1'b1;
				end
				else if (bypass_en && (pg_req || ms_req))
					st_next.state = fes_pkg::FES_UNLOCKED;
			end
			fes_pkg::FES_KEY1:
			begin
				if (bypass_en)
					st_next.state = fes_pkg::FES_LOCKED;
				else if (ctl_wr)
					st_next.state = (ctl_wdata == fes_pkg::KEY_SECOND) ?
						fes_pkg::FES_UNLOCKED : fes_pkg::FES_LOCKED;
			end
			fes_pkg::FES_UNLOCKED:
			begin
				if (ms_req && (ctl_from_dbg || bypass_en))
				begin
					st_next.is_mass = 1'b1;
					st_next.state = fes_pkg::FES_ERASING;
					tmr_load = 1'b1;
					tmr_count = TMR_W'(MASS_ERASE_CYC);
				end
				else if (pg_req && !page_protected(page_sel, sect_protect))
				begin
					st_next.is_mass = 1'b0;
					st_next.page = page_sel;
					st_next.state = fes_pkg::FES_ERASING;
					tmr_load = 1'b1;
					tmr_count = TMR_W'(PAGE_ERASE_CYC);
				end
				// core mass erase refused, protected page refused
				else if (pg_req || ms_req || (ctl_wr && !bypass_en))
				begin
					st_next.rej = 1'b1;
					st_next.state = fes_pkg::FES_LOCKED;
				end
				if (st_next.state == fes_pkg::FES_ERASING)
				begin
					st_next.busy = 1'b1;
					st_next.stall = !bypass_en;
				end
			end
			fes_pkg::FES_ERASING:
			begin
				if (tmr_done)
				begin
					// one page sweep, whole array sweep
					sw_start = 1'b1;
					sw_base = st_reg.is_mass ? '0 : page_base(st_reg.page);
					sw_len = st_reg.is_mass ? (ADDR_W+1)'(1 << ADDR_W) :
						(ADDR_W+1)'(fes_pkg::PAGE_BYTES);
					st_next.state = fes_pkg::FES_WRITING;
				end
			end
			fes_pkg::FES_WRITING:
			begin
				if (sw_done)
				begin
					st_next.busy = 1'b0;
					st_next.stall = 1'b0;
					st_next.state = fes_pkg::FES_LOCKED;
				end
			end
			default:
				st_next.state = fes_pkg::FES_LOCKED;
		endcase
		// unlocked flag kept in a flop so the port is registered
		st_next.unl = (st_next.state == fes_pkg::FES_UNLOCKED);
		// pins drive array in bypass when idle
		if (bypass_en && !st_reg.busy)
		begin
			st_next.fl_wr_en = pin_wr_en;
			st_next.fl_addr = pin_addr;
			st_next.fl_data = pin_data;
		end
		else
		begin
			st_next.fl_wr_en = sw_wr;
			st_next.fl_addr = sw_addr;
			st_next.fl_data = sw_data;
		end
	end
	//==============================
	// state register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_reg <= '0;
			st_reg.state <= fes_pkg::FES_LOCKED;
		end
		else
			st_reg <= st_next;
	end
	//==============================
	// registered outputs
	assign busy = st_reg.busy;
	assign unlocked = st_reg.unl;
	assign cpu_stall = st_reg.stall;
	assign cmd_rejected = st_reg.rej;
	assign fl_wr_en = st_reg.fl_wr_en;
	assign fl_addr = st_reg.fl_addr;
	assign fl_data = st_reg.fl_data;
endmodule

// ===== shared/fes_pkg.sv
// constants and types shared by the flash erase sequencer
//==============================
package fes_pkg;
	//==============================
	// commands, unlock keys and erased fill byte
	localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
	localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
	localparam logic [7:0] KEY_FIRST = 8'h73;
	localparam logic [7:0] KEY_SECOND = 8'h8c;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	//==============================
	// array geometry
	localparam int PAGE_BYTES = 512;
	localparam int PAGE_ADDR_W = 9;
	//==============================
	// timing
	localparam int CLK_MHZ = 250;
	localparam int PAGE_ERASE_US = 10;
	localparam int MASS_ERASE_US = 20;
	localparam int PAGE_ERASE_CYC = PAGE_ERASE_US * CLK_MHZ;
	localparam int MASS_ERASE_CYC = MASS_ERASE_US * CLK_MHZ;
	//==============================
	// sequencer states
	typedef enum logic [2:0] {
		FES_LOCKED,
		FES_KEY1,
		FES_UNLOCKED,
		FES_ERASING,
		FES_WRITING
	} fes_state_e;
endpackage

// ===== verification/fes_flash_model.sv
// behavioural flash array seen by the sequencer write port
module fes_flash_model #(
	parameter int ADDR_W = 13
) (
	// clock
	input wire logic clk,
	// write port
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	// bench read port
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [7:0] rd_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem_reg [0:(1<<ADDR_W)-1];
	// preload a pattern that is not all ones near page edges
	initial
	begin
		for (int i = 0; i < (1 << ADDR_W); i++)
			mem_reg[i] = i[7:0] ^ 8'h5a;
	end
	always @(posedge clk)
	begin
		if (wr_en)
			mem_reg[wr_addr] <= wr_data;
	end
	assign rd_data = mem_reg[rd_addr];
endmodule

// ===== verification/fes_top_properties.sv
// port checks for the flash erase sequencer
module fes_props #(
	parameter int ADDR_W = 13,
	parameter int PAGE_W = 4,
	parameter int SECT_N = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// requests
	input wire logic ctl_wr,
	input wire logic [7:0] ctl_wdata,
	input wire logic ctl_from_dbg,
	input wire logic [PAGE_W-1:0] page_sel,
	input wire logic [SECT_N-1:0] sect_protect,
	input wire logic bypass_en,
	input wire logic pin_wr_en,
	input wire logic [ADDR_W-1:0] pin_addr,
	input wire logic [7:0] pin_data,
	// results
	input wire logic busy,
	input wire logic unlocked,
	input wire logic cpu_stall,
	input wire logic cmd_rejected,
	input wire logic fl_wr_en,
	input wire logic [ADDR_W-1:0] fl_addr,
	input wire logic [7:0] fl_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic prot;
	logic go;
	// selected page protection and unlocked command write
	assign prot = sect_protect[page_sel[PAGE_W-1:1]];
	assign go = ctl_wr && unlocked && !bypass_en;
	page_start_a: assert property (go && ctl_wdata == 8'h95 && !prot
		|=> busy && cpu_stall && !unlocked) else $error("page erase not started");
	prot_refuse_a: assert property (go && ctl_wdata == 8'h95 && prot
		|=> cmd_rejected && !busy) else $error("protected page not refused");
	mass_start_a: assert property (go && ctl_wdata == 8'h63 && ctl_from_dbg
		|=> busy && cpu_stall) else $error("mass erase not started");
	core_mass_a: assert property (go && ctl_wdata == 8'h63 && !ctl_from_dbg
		|=> cmd_rejected && !busy && !unlocked) else $error("core mass erase taken");
	busy_locked_a: assert property (busy |-> !unlocked)
		else $error("unlocked during erase");
	stall_busy_a: assert property (cpu_stall |-> busy && !bypass_en)
		else $error("stall outside erase");
	sweep_step_a: assert property (fl_wr_en && $past(fl_wr_en) && busy
		|-> fl_addr == $past(fl_addr) + 1'b1 && fl_data == 8'hff) else $error("bad fill");
	pin_pass_a: assert property (bypass_en && !busy && pin_wr_en
		|=> fl_wr_en && fl_addr == $past(pin_addr) && fl_data == $past(pin_data))
		else $error("pin write lost");
endmodule
bind fes_top fes_props #(.ADDR_W(ADDR_W), .PAGE_W(PAGE_W), .SECT_N(SECT_N)) fes_props_inst (.*);

// ===== verification/fes_top_tb.sv
// self-checking bench for the flash erase sequencer
module fes_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ctl_wr = 1'b0;
	logic [7:0] ctl_wdata = 8'h00;
	logic ctl_from_dbg = 1'b0;
	logic [3:0] page_sel = 4'h0;
	logic [7:0] sect_protect = 8'h00;
	logic bypass_en = 1'b0;
	logic pin_wr_en = 1'b0;
	logic [12:0] pin_addr = 13'h0000;
	logic [7:0] pin_data = 8'h00;
	logic pin_page = 1'b0;
	logic pin_mass = 1'b0;
	logic busy, unlocked, cpu_stall, cmd_rejected, fl_wr_en;
	logic [12:0] fl_addr;
	logic [12:0] rd_addr = 13'h0000;
	logic [7:0] fl_data, rd_data;
	logic [20:0] exp_q [$];
	int fails = 0;
	int samples_checked = 0;
	int seed = 53831;
	int base;
	fes_top #(.PAGE_ERASE_CYC(4), .MASS_ERASE_CYC(4)) fes_top_inst (.clk(clk), .rst(rst),
		.ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .ctl_from_dbg(ctl_from_dbg),
		.page_sel(page_sel), .sect_protect(sect_protect), .bypass_en(bypass_en),
		.pin_wr_en(pin_wr_en), .pin_addr(pin_addr), .pin_data(pin_data),
		.pin_page_erase(pin_page), .pin_mass_erase(pin_mass), .busy(busy), .unlocked(unlocked),
		.cpu_stall(cpu_stall), .cmd_rejected(cmd_rejected), .fl_wr_en(fl_wr_en),
		.fl_addr(fl_addr), .fl_data(fl_data));
	fes_flash_model fes_flash_model_inst (.clk(clk), .wr_en(fl_wr_en), .wr_addr(fl_addr),
		.wr_data(fl_data), .rd_addr(rd_addr), .rd_data(rd_data));
	// clock
	always #2 clk = ~clk;
	//==============================
	// shared tasks
	task automatic chk(input string what, input logic [20:0] seen, input logic [20:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic send(input logic [23:0] seq, input int n, input logic dbg);
		for (int i = n - 1; i >= 0; i--)
		begin
			@(negedge clk);
			ctl_wr = 1'b1;
			ctl_wdata = seq[i*8 +: 8];
			ctl_from_dbg = dbg;
		end
		@(negedge clk);
		ctl_wr = 1'b0;
	endtask
	task automatic fill(input int b, input int len);
		for (int i = 0; i < len; i++)
			exp_q.push_back({13'(b + i), 8'hff});
	endtask
	task automatic wait_idle();
		// poll busy until the erase reports done
		for (int i = 0; i < 9000 && busy !== 1'b0; i++)
			@(negedge clk);
		// let the write monitor take the last fill first
		@(negedge clk);
		chk("fill left", 21'(exp_q.size()), 21'h0);
	endtask
	task automatic peek(input int a, input logic [7:0] exp);
		rd_addr = 13'(a);
		#1;
		chk("array byte", 21'(rd_data), 21'(exp));
	endtask
	// each array write must match the oldest expected fill
	always @(negedge clk)
	begin
		if (fl_wr_en === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk("stray write", 21'h1, 21'h0);
			else
				chk("array write", {fl_addr, fl_data}, exp_q.pop_front());
		end
	end
	// watchdog
	initial
	begin
		#200000;
		fails++;
		wrap_up();
	end
	//==============================
	// scenarios
	initial
	begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		chk("idle", {busy, unlocked, cpu_stall, cmd_rejected, fl_wr_en}, 21'h0);
		send(24'h000095, 1, 1'b1);
		chk("locked cmd", 21'(cmd_rejected), 21'h1);
		sect_protect = (8'($random(seed)) | 8'h01) & 8'h7f;
		page_sel = {3'h0, 1'($random(seed))};
		send(24'h738c95, 3, 1'b0);
		chk("protected", {cmd_rejected, busy}, 21'h2);
		page_sel = {3'h7, 1'($random(seed))};
		base = page_sel * 512;
		fill(base, 512);
		send(24'h738c95, 3, 1'b0);
		chk("page start", {busy, cpu_stall, unlocked}, 21'h6);
		page_sel = 4'h0;
		send(24'h738c63, 3, 1'b1);
		wait_idle();
		chk("page end", {cpu_stall, unlocked}, 21'h0);
		peek(base + 511, 8'hff);
		peek(base - 1, 8'(base - 1) ^ 8'h5a);
		send(24'h738c63, 3, 1'b0);
		chk("core mass", {cmd_rejected, busy, unlocked}, 21'h4);
		fill(0, 8192);
		send(24'h738c63, 3, 1'b1);
		chk("mass start", 21'(busy), 21'h1);
		wait_idle();
		chk("mass end", {cpu_stall, unlocked}, 21'h0);
		peek(8191, 8'hff);
		bypass_en = 1'b1;
		sect_protect = 8'h00;
		@(negedge clk);
		pin_wr_en = 1'b1;
		pin_addr = 13'($random(seed));
		pin_data = 8'($random(seed));
		exp_q.push_back({pin_addr, pin_data});
		@(negedge clk);
		pin_wr_en = 1'b0;
		page_sel = 4'($random(seed));
		fill(page_sel * 512, 512);
		repeat (2)
		begin
			@(negedge clk);
			pin_page = 1'b1;
			@(negedge clk);
			pin_page = 1'b0;
		end
		chk("no stall", 21'(cpu_stall), 21'h0);
		wait_idle();
		chk("bypass done", 21'(busy), 21'h0);
		fill(0, 8192);
		repeat (2)
		begin
			@(negedge clk);
			pin_mass = 1'b1;
			@(negedge clk);
			pin_mass = 1'b0;
		end
		chk("pin mass start", {busy, cpu_stall}, 21'h2);
		wait_idle();
		peek(0, 8'hff);
		wrap_up();
	end
endmodule
